// ==== dtx_burst.sv ====
module dtx_burst
   import dtx_pkg::*;
#(
   parameter int BURST_CYC = 1000000,
   parameter int PAUSE_CYC = 1000000
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // digit codes in
   input wire logic [3:0] code_i,
   input wire logic valid_i,
   output logic ready_o,
   // mode and stop
   input wire logic burst_mode_i,
   input wire logic stop_i,
   // tone pair selection out
   output logic tone_on_o,
   output logic [3:0] tone_code_o
);
   localparam int MAXC = (BURST_CYC > PAUSE_CYC) ? BURST_CYC : PAUSE_CYC;
   localparam int CW = $clog2(MAXC + 1);
   if (BURST_CYC < 1 || PAUSE_CYC < 1) begin : g_bad_time
      $error("dtx_burst: burst and pause must last at least one cycle");
   end
   dtx_tx_e state;
   logic [CW-1:0] cnt;  // cycles spent in tone or pause
   // continuous mode swaps the digit at once, burst mode waits for idle
   assign ready_o = !stop_i && (state == DTX_TX_IDLE || (!burst_mode_i && state == DTX_TX_TONE));
   // burst counter: tone for a fixed time, then a fixed silent gap
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= DTX_TX_IDLE;
         cnt <= '0;
         tone_on_o <= 1'b0;
         tone_code_o <= 4'h0;
      end else if (stop_i) begin
         state <= DTX_TX_IDLE;  // generator disabled, tone dies now
         tone_on_o <= 1'b0;
      end else begin
         case (state)
            DTX_TX_IDLE: begin
               if (valid_i) begin
                  tone_code_o <= code_i;
                  tone_on_o <= 1'b1;
                  cnt <= '0;
                  state <= DTX_TX_TONE;
               end
            end
            DTX_TX_TONE: begin
               if (burst_mode_i) begin
                  if (cnt == CW'(BURST_CYC - 1)) begin
                     cnt <= '0;
                     tone_on_o <= 1'b0;
                     state <= DTX_TX_PAUSE;
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end else if (valid_i) begin
                  tone_code_o <= code_i;  // continuous: next digit replaces
               end
            end
            DTX_TX_PAUSE: begin
               if (cnt == CW'(PAUSE_CYC - 1)) begin
                  state <= DTX_TX_IDLE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state <= DTX_TX_IDLE;
               tone_on_o <= 1'b0;
            end
         endcase
      end
   end
endmodule : dtx_burst

// ==== dtx_defs.svh ====
`ifndef DTX_DEFS_SVH
`define DTX_DEFS_SVH
// ************************************************************
// clock and host port timing
// ************************************************************
`define DTX_CLK_HZ 20000000
`define DTX_CLK_PERIOD_NS 50
`define DTX_HOST_PORT_MHZ 2
`define DTX_HOST_MIN_CYC ((1000 / `DTX_HOST_PORT_MHZ + `DTX_CLK_PERIOD_NS - 1) / `DTX_CLK_PERIOD_NS)
`define DTX_SYNC_STAGES 3
// ************************************************************
// receiver and generator timing
// ************************************************************
`define DTX_SETTLE_NS 200
`define DTX_SETTLE_CYC ((`DTX_SETTLE_NS + `DTX_CLK_PERIOD_NS - 1) / `DTX_CLK_PERIOD_NS)
`define DTX_BURST_MS 50
`define DTX_PAUSE_MS 50
`define DTX_BURST_CYC (`DTX_BURST_MS * (`DTX_CLK_HZ / 1000))
`define DTX_PAUSE_CYC (`DTX_PAUSE_MS * (`DTX_CLK_HZ / 1000))
`define DTX_TX_DEPTH 16
// ************************************************************
// register select codes and field positions
// ************************************************************
`define DTX_RS_DATA 1'h0
`define DTX_RS_CTRL 1'h1
`define DTX_CTA_TONE_EN 0
`define DTX_CTA_CP_MODE 1
`define DTX_CTA_IRQ_EN 2
`define DTX_CTA_SEL_B 3
`define DTX_CTB_BURST 0
`define DTX_ST_NEW_DIGIT 0
`define DTX_ST_TX_READY 1
`define DTX_ST_DSF 2
`define DTX_ST_TX_EMPTY 3
// ************************************************************
// reset values
// ************************************************************
`define DTX_CTA_RST 4'h0
`define DTX_CTB_RST 4'h1
`define DTX_RX_RST 4'h0
`define DTX_SYNC_RST 10'h380
`endif

// ==== dtx_fifo.sv ====
module dtx_fifo
   import dtx_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   // pointer wrap relies on a power of two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("dtx_fifo: DEPTH must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];  // storage words
   logic [AW-1:0] wr_ptr;  // next slot to fill
   logic [AW-1:0] rd_ptr;  // oldest word
   logic [CW-1:0] count;  // words held
   logic push;
   logic pop;
   assign in_ready_o = (count != CW'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   // storage has no reset: only words behind count are ever read
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   // pointers and fill level
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end
endmodule : dtx_fifo

// ==== dtx_host_model.sv ====
module dtx_host_model (
   // clock
   input wire logic ref_clk_i,
   // device side of the bus
   input wire logic [3:0] dev_bus_i,
   input wire logic dev_oe_i,
   // strobes and bus level
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic rs_o,
   output logic [3:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] drv = 4'h0; // write data
   logic drv_en = 1'b0; // host drives bus
   logic [3:0] noise = 4'h3; // floating bus, changes each cycle
   initial {cs_n_o, rd_n_o, wr_n_o, rs_o} = 4'hE;
   assign bus_o = dev_oe_i ? dev_bus_i : (drv_en ? drv : noise);
   always @(posedge ref_clk_i) noise <= noise + 4'h5;
   // one nibble access; hold of 8+ cycles keeps under 2 MHz
   task access(input logic rs, input logic wr, input logic [3:0] d, input int hold);
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      rs_o <= rs;
      wr_n_o <= !wr;
      rd_n_o <= wr;
      drv <= d;
      drv_en <= wr;
      repeat (hold) @(posedge ref_clk_i);
      {cs_n_o, rd_n_o, wr_n_o} <= 3'h7;
      repeat (3) @(posedge ref_clk_i);
      drv_en <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask : access
endmodule : dtx_host_model

// ==== dtx_host_port.sv ====
// How it works
// - chip select low marks every access
// - write data taken while write and select low
// - bus driven only while read and select low
// - select line and direction pick five registers
// - one nibble moves per access, one bus
// - interrupt pin only pulls low, never drives high
// - call progress mode with irq enable puts square wave on pin
// - early steer rises once tone pair valid, outside call progress mode
// - early steer drops at once on loss
// - steering rise registers detected pair, updates latch
// - steering fall rearms for next tone pair
// - guard output from early steer and steering
// - burst counter times tone bursts and pauses
// - control register selects call progress mode
// - host port serves strobes up to 2 MHz
// - all timing counted from one oscillator clock
// - registration latches four bit code to receive
// - interrupt pulls low while delayed steering active
// - no digit registration in call progress mode
// - transmit codes use receiver digit encoding
`include "dtx_defs.svh"
module dtx_host_port
   import dtx_pkg::*;
#(
   parameter int BURST_CYC = `DTX_BURST_CYC,
   parameter int PAUSE_CYC = `DTX_PAUSE_CYC,
   parameter int TX_DEPTH = `DTX_TX_DEPTH,
   parameter int SETTLE_CYC = `DTX_SETTLE_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host strobes and select
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic register_selector_i,
   // host nibble bus, split into three signals
   input wire logic [3:0] host_nibble_bus_i,
   output logic [3:0] host_nibble_bus_o,
   output logic host_nibble_bus_oe_o,
   // open-drain interrupt / call progress pin
   output logic interrupt_or_progress_out_n_o,
   output logic interrupt_or_progress_out_n_oe_o,
   // tone detector, same clock
   input wire logic det_valid_i,
   input wire logic [3:0] det_code_i,
   // call progress comparator, asynchronous
   input wire logic cp_square_i,
   // early steering and steering / guard pin
   output logic early_steer_flag_o,
   input wire logic steering_guard_pin_i,
   output logic steering_guard_pin_o,
   output logic steering_guard_pin_oe_o,
   // tone generator selection
   output logic tone_on_o,
   output logic [3:0] tone_code_o
);
   // ************************************************************
   // elaboration checks
   // ************************************************************
   localparam int NSYNC = 10;  // bits that cross from the pins
   localparam int SW = $clog2(SETTLE_CYC + 1);
   // a strobe shorter than the synchroniser delay would be missed
   if (`DTX_HOST_MIN_CYC <= `DTX_SYNC_STAGES) begin : g_bad_rate
      $error("dtx_host_port: clock too slow for host port rate");
   end
   if (SETTLE_CYC < 1 || TX_DEPTH < 2) begin : g_bad_par
      $error("dtx_host_port: settle time or fifo depth out of range");
   end

   // ************************************************************
   // decode helpers
   // ************************************************************
   // select line picks the data pair or the control/status pair
   function automatic logic sel_is_data(input logic rs);
      return rs == `DTX_RS_DATA;
   endfunction : sel_is_data

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [NSYNC-1:0] sync_in;  // raw pin levels
   logic [NSYNC-1:0] sync_s1;  // first stage, read by stage two only
   logic [NSYNC-1:0] sync_s2;  // second stage
   logic [NSYNC-1:0] sync_s3;  // third stage
   logic [NSYNC-1:0] sync_lvl;  // accepted level
   assign sync_in = {cs_n_i, rd_n_i, wr_n_i, register_selector_i, host_nibble_bus_i,
                     steering_guard_pin_i, cp_square_i};
   // four flops per bit, level moves once stages two and three agree
   for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            sync_s1[gi] <= 1'(`DTX_SYNC_RST >> gi);
            sync_s2[gi] <= 1'(`DTX_SYNC_RST >> gi);
            sync_s3[gi] <= 1'(`DTX_SYNC_RST >> gi);
            sync_lvl[gi] <= 1'(`DTX_SYNC_RST >> gi);
         end else begin
            sync_s1[gi] <= sync_in[gi];
            sync_s2[gi] <= sync_s1[gi];
            sync_s3[gi] <= sync_s2[gi];
            if (sync_s2[gi] == sync_s3[gi]) begin
               sync_lvl[gi] <= sync_s3[gi];
            end
         end
      end
   end
   // clean levels
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic rs;
   dtx_nib_t bus_in;
   logic steer_hi;
   logic cp_lvl;
   assign {cs_n, rd_n, wr_n, rs, bus_in, steer_hi, cp_lvl} = sync_lvl;

   // ************************************************************
   // access decode
   // ************************************************************
   logic rd_act;  // read interval in progress
   logic wr_act;  // write interval in progress
   logic rd_act_q;  // read interval, one cycle late
   logic wr_act_q;  // write interval, one cycle late
   logic rd_end;  // read interval just closed
   logic wr_end;  // write interval just closed
   dtx_nib_t wr_data;  // last nibble seen inside the write interval
   logic wr_rs;  // select held for the write
   logic rd_rs;  // select held for the read
   assign rd_act = !cs_n && !rd_n && wr_n;
   assign wr_act = !cs_n && !wr_n && rd_n;
   assign rd_end = rd_act_q && !rd_act;
   assign wr_end = wr_act_q && !wr_act;
   // interval tracking and capture of write data and select
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         wr_data <= 4'h0;
         wr_rs <= 1'b0;
         rd_rs <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         // keep sampling while low: the host's data is settled at the end
         if (wr_act) begin
            wr_data <= bus_in;
            wr_rs <= rs;
         end
         if (rd_act) begin
            rd_rs <= rs;
         end
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   dtx_nib_t ctrl_a;  // tone enable, call progress, irq enable, select b
   dtx_nib_t ctrl_b;  // burst mode
   logic cp_mode;
   assign cp_mode = ctrl_a[`DTX_CTA_CP_MODE];
   // writes commit when the strobe is released
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_a <= `DTX_CTA_RST;
         ctrl_b <= `DTX_CTB_RST;
      end else if (wr_end && !sel_is_data(wr_rs)) begin
         if (ctrl_a[`DTX_CTA_SEL_B]) begin
            ctrl_b <= wr_data;
            ctrl_a[`DTX_CTA_SEL_B] <= 1'b0;  // next write reaches a again
         end else begin
            ctrl_a <= wr_data;
         end
      end
   end

   // ************************************************************
   // transmit path
   // ************************************************************
   logic tx_push;  // one-cycle push toward the fifo
   dtx_nib_t tx_push_data;
   logic tx_in_ready;  // fifo has room
   dtx_nib_t tx_head;
   logic tx_head_valid;
   logic tx_head_ready;
   logic tone_en;
   assign tone_en = ctrl_a[`DTX_CTA_TONE_EN];
   // a transmit write becomes one push; a full fifo drops the nibble
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_push <= 1'b0;
         tx_push_data <= 4'h0;
      end else begin
         tx_push <= wr_end && sel_is_data(wr_rs) && tx_in_ready;
         tx_push_data <= wr_data;
      end
   end
   // digits queue here so software can write ahead of the bursts
   dtx_fifo #(
      .WIDTH(4),
      .DEPTH(TX_DEPTH)
   ) u_tx_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_data_i(tx_push_data),
      .in_valid_i(tx_push),
      .in_ready_o(tx_in_ready),
      .out_data_o(tx_head),
      .out_valid_o(tx_head_valid),
      .out_ready_i(tx_head_ready)
   );
   // generator stalls the fifo while a burst or pause runs
   dtx_burst #(
      .BURST_CYC(BURST_CYC),
      .PAUSE_CYC(PAUSE_CYC)
   ) u_burst (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .code_i(tx_head),
      .valid_i(tx_head_valid),
      .ready_o(tx_head_ready),
      .burst_mode_i(ctrl_b[`DTX_CTB_BURST]),
      .stop_i(!tone_en),
      .tone_on_o(tone_on_o),
      .tone_code_o(tone_code_o)
   );

   // ************************************************************
   // receiver steering
   // ************************************************************
   logic early_steer_flag;  // early steering, digits only outside call progress
   dtx_rx_e rx_state;
   logic [SW-1:0] settle_cnt;  // latch settle delay
   dtx_nib_t rx_data;  // receive data register
   logic dsf;  // delayed steering flag
   logic new_digit;  // sticky, cleared by reading receive data
   logic steer_q;  // steering level one cycle ago
   logic steer_rise;
   assign early_steer_flag = det_valid_i && !cp_mode;
   assign steer_rise = steer_hi && !steer_q;
   // early steer follows the detector with no filtering
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         early_steer_flag_o <= 1'b0;
      end else begin
         early_steer_flag_o <= early_steer_flag;
      end
   end
   // guard output charges the time constant while both agree
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         steering_guard_pin_o <= 1'b0;
         steering_guard_pin_oe_o <= 1'b0;
      end else begin
         steering_guard_pin_o <= early_steer_flag && steer_hi;
         steering_guard_pin_oe_o <= 1'b1;
      end
   end
   // register on steering rise, flag after the latch settles
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         steer_q <= 1'b0;
         rx_state <= DTX_RX_ARMED;
         settle_cnt <= '0;
         rx_data <= `DTX_RX_RST;
         dsf <= 1'b0;
      end else begin
         steer_q <= steer_hi;
         case (rx_state)
            DTX_RX_ARMED: begin
               dsf <= 1'b0;
               if (steer_rise && !cp_mode) begin
                  rx_data <= det_code_i;
                  settle_cnt <= '0;
                  rx_state <= DTX_RX_SETTLE;
               end
            end
            DTX_RX_SETTLE: begin
               if (!steer_hi) begin
                  rx_state <= DTX_RX_ARMED;
               end else if (settle_cnt == SW'(SETTLE_CYC - 1)) begin
                  dsf <= 1'b1;
                  rx_state <= DTX_RX_HELD;
               end else begin
                  settle_cnt <= settle_cnt + 1'b1;
               end
            end
            DTX_RX_HELD: begin
               // the pair stays held until steering drops below threshold
               if (!steer_hi) begin
                  dsf <= 1'b0;
                  rx_state <= DTX_RX_ARMED;
               end
            end
            default: begin
               dsf <= 1'b0;
               rx_state <= DTX_RX_ARMED;
            end
         endcase
      end
   end
   // new digit flag: a set in the clearing cycle wins
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         new_digit <= 1'b0;
      end else if (rx_state == DTX_RX_SETTLE && steer_hi && settle_cnt == SW'(SETTLE_CYC - 1)) begin
         new_digit <= 1'b1;
      end else if (rd_end && sel_is_data(rd_rs)) begin
         new_digit <= 1'b0;
      end
   end

   // ************************************************************
   // interrupt / call progress pin
   // ************************************************************
   // low level is fixed: the pin is only ever pulled down or released
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interrupt_or_progress_out_n_o <= 1'b0;
         interrupt_or_progress_out_n_oe_o <= 1'b0;
      end else begin
         interrupt_or_progress_out_n_o <= 1'b0;
         if (!ctrl_a[`DTX_CTA_IRQ_EN]) begin
            interrupt_or_progress_out_n_oe_o <= 1'b0;
         end else if (cp_mode) begin
            interrupt_or_progress_out_n_oe_o <= !cp_lvl;
         end else begin
            interrupt_or_progress_out_n_oe_o <= dsf;
         end
      end
   end

   // ************************************************************
   // read side of the host bus
   // ************************************************************
   dtx_nib_t status;
   assign status = {!tx_head_valid, dsf, tx_in_ready, new_digit};
   // bus drives the chosen register only during the read interval
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_nibble_bus_o <= 4'h0;
         host_nibble_bus_oe_o <= 1'b0;
      end else begin
         host_nibble_bus_oe_o <= rd_act;
         if (!rd_act) begin
            host_nibble_bus_o <= 4'h0;
         end else if (sel_is_data(rs)) begin
            host_nibble_bus_o <= rx_data;
         end else begin
            host_nibble_bus_o <= status;
         end
      end
   end
endmodule : dtx_host_port

// ==== dtx_host_port_monitor.sv ====
module dtx_host_port_monitor
   import dtx_pkg::*;
#(
   parameter int BURST_CYC = 20,
   parameter int PAUSE_CYC = 20
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // watched pins
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic det_valid_i,
   input wire logic [3:0] host_nibble_bus_o,
   input wire logic host_nibble_bus_oe_o,
   input wire logic interrupt_or_progress_out_n_o,
   input wire logic early_steer_flag_o,
   input wire logic steering_guard_pin_o,
   input wire logic tone_on_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   int on_cnt; // cycles tone on
   int off_cnt; // cycles tone off
   // run lengths of the tone output
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         on_cnt <= 0;
         off_cnt <= 0;
      end else begin
         on_cnt <= tone_on_o ? on_cnt + 1 : 0;
         off_cnt <= tone_on_o ? 0 : off_cnt + 1;
      end
   end
   sequence s_rd_held;
      (!cs_n_i && !rd_n_i && wr_n_i) [*6];
   endsequence
   sequence s_idle;
      cs_n_i [*7];
   endsequence
   property p_rd_drive;
      s_rd_held |-> host_nibble_bus_oe_o;
   endproperty
   property p_oe_cause;
      $rose(host_nibble_bus_oe_o) |-> $past(!cs_n_i && !rd_n_i && wr_n_i, 4);
   endproperty
   property p_idle_free;
      s_idle |-> !host_nibble_bus_oe_o;
   endproperty
   property p_bus_zero;
      !host_nibble_bus_oe_o |-> host_nibble_bus_o == 4'h0;
   endproperty
   property p_irq_drain;
      interrupt_or_progress_out_n_o == 1'b0;
   endproperty
   property p_est_rise;
      $rose(early_steer_flag_o) |-> $past(det_valid_i);
   endproperty
   property p_est_drop;
      !det_valid_i |=> !early_steer_flag_o;
   endproperty
   property p_guard;
      !early_steer_flag_o |-> !steering_guard_pin_o;
   endproperty
   property p_burst;
      $fell(tone_on_o) |-> on_cnt == BURST_CYC;
   endproperty
   property p_pause;
      $rose(tone_on_o) |-> off_cnt >= PAUSE_CYC;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("bus not driven in read");
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
   a_idle_free: assert property (p_idle_free) else $error("bus held while idle");
   a_bus_zero: assert property (p_bus_zero) else $error("bus data not zero");
   a_irq_drain: assert property (p_irq_drain) else $error("irq pin driven high");
   a_est_rise: assert property (p_est_rise) else $error("early steer rose alone");
   a_est_drop: assert property (p_est_drop) else $error("early steer held");
   a_guard: assert property (p_guard) else $error("guard high without steer");
   a_burst: assert property (p_burst) else $error("burst length off");
   a_pause: assert property (p_pause) else $error("pause too short");
endmodule : dtx_host_port_monitor
bind dtx_host_port dtx_host_port_monitor #(.BURST_CYC(BURST_CYC), .PAUSE_CYC(PAUSE_CYC)) i_mon (.*);

// ==== dtx_pkg.sv ====
package dtx_pkg;
   // one nibble of the host port
   typedef logic [3:0] dtx_nib_t;
   // receive steering sequence, gray along armed-settle-held
   typedef enum logic [1:0] {
      DTX_RX_ARMED = 2'b00,
      DTX_RX_SETTLE = 2'b01,
      DTX_RX_HELD = 2'b11
   } dtx_rx_e;
   // tone generator sequence, gray along idle-tone-pause
   typedef enum logic [1:0] {
      DTX_TX_IDLE = 2'b00,
      DTX_TX_TONE = 2'b01,
      DTX_TX_PAUSE = 2'b11
   } dtx_tx_e;
endpackage : dtx_pkg

// ==== dtx_tb.sv ====
module tb
   import dtx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, det_valid = 1'b0, cp_sq = 1'b1, steer = 1'b0;
   logic cs_n, rd_n, wr_n, rs, oe, irq_n, irq_oe, early_steer_flag, gd, gd_oe, ton, oe_d = 0, ton_d = 0;
   logic [3:0] bus_i, bus_o, tcode, dat_d;
   dtx_nib_t det_code = 4'h0, code;
   dtx_nib_t exp_q[$], tone_q[$];
   logic [15:0] seed = 16'h120A;
   int num_errors = 0, n_checks = 0;
   // one step of the stimulus lfsr
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   dtx_host_port #(.BURST_CYC(20), .PAUSE_CYC(20)) i_dtx_host_port (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .register_selector_i(rs), .host_nibble_bus_i(bus_i), .host_nibble_bus_o(bus_o),
      .host_nibble_bus_oe_o(oe), .interrupt_or_progress_out_n_o(irq_n),
      .interrupt_or_progress_out_n_oe_o(irq_oe), .det_valid_i(det_valid),
      .det_code_i(det_code), .cp_square_i(cp_sq), .early_steer_flag_o(early_steer_flag),
      .steering_guard_pin_i(steer), .steering_guard_pin_o(gd),
      .steering_guard_pin_oe_o(gd_oe), .tone_on_o(ton), .tone_code_o(tcode));
   dtx_host_model i_dtx_host_model (.ref_clk_i(ref_clk_i), .dev_bus_i(bus_o),
      .dev_oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .rs_o(rs), .bus_o(bus_i));
   initial forever #25 ref_clk_i = ~ref_clk_i;
   task chk(input dtx_nib_t e, input dtx_nib_t g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : step
   // host access, hold length from the lfsr
   task acc(input logic s, input logic w, input dtx_nib_t d);
      seed = lfsr(seed);
      i_dtx_host_model.access(s, w, d, 8 + seed[1:0]);
   endtask : acc
   task rd(input logic s, input dtx_nib_t e);
      exp_q.push_back(e);
      acc(s, 1'b0, 4'h0);
   endtask : rd
   task look(input logic g, input logic e);
      @(negedge ref_clk_i);
      chk({3'h0, e}, {3'h0, g});
      @(posedge ref_clk_i);
   endtask : look
   task complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // result watcher: reads at end of drive, tones at burst start
   always @(posedge ref_clk_i) begin
      if (oe_d && !oe) chk(exp_q.pop_front(), dat_d);
      if (ton && !ton_d) chk(tone_q.pop_front(), tcode);
      oe_d <= oe;
      dat_d <= bus_o;
      ton_d <= ton;
   end
   initial begin
      step(20000);
      num_errors++;
      complete_run();
   end
   initial begin
      step(12);
      rst_n_i <= 1'b1;
      rd(1'b1, 4'hA);
      rd(1'b0, 4'h0);
      seed = lfsr(seed);
      code = seed[3:0];
      det_code <= code;
      det_valid <= 1'b1;
      step(3);
      look(early_steer_flag, 1'b1);
      steer <= 1'b1;
      step(12);
      look(gd, 1'b1);
      look(gd_oe, 1'b1);
      rd(1'b1, 4'hF);
      rd(1'b0, code);
      rd(1'b1, 4'hE);
      acc(1'b1, 1'b1, 4'h4);
      look(irq_oe, 1'b1);
      det_valid <= 1'b0;
      steer <= 1'b0;
      step(8);
      look(irq_oe, 1'b0);
      look(early_steer_flag, 1'b0);
      acc(1'b1, 1'b1, 4'h6);
      det_valid <= 1'b1;
      steer <= 1'b1;
      step(12);
      rd(1'b1, 4'hA);
      look(early_steer_flag, 1'b0);
      cp_sq <= 1'b0;
      step(8);
      look(irq_oe, 1'b1);
      cp_sq <= 1'b1;
      step(8);
      look(irq_oe, 1'b0);
      det_valid <= 1'b0;
      steer <= 1'b0;
      acc(1'b1, 1'b1, 4'h0);
      for (int k = 0; k < 17; k++) begin
         seed = lfsr(seed);
         if (k < 16) tone_q.push_back(seed[3:0]);
         acc(1'b0, 1'b1, seed[3:0]);
      end
      rd(1'b1, 4'h0);
      acc(1'b1, 1'b1, 4'h1);
      for (int k = 0; k < 2000 && tone_q.size() > 0; k++) step(1);
      step(30);
      rd(1'b1, 4'hA);
      // select b, continuous mode: second digit replaces the first at once
      acc(1'b1, 1'b1, 4'h9);
      acc(1'b1, 1'b1, 4'h0);
      tone_q.push_back(4'h5);
      acc(1'b0, 1'b1, 4'h5);
      acc(1'b0, 1'b1, 4'h7);
      look(ton, 1'b1);
      chk(4'h7, tcode);
      chk(4'h0, 4'(tone_q.size()));
      complete_run();
   end
endmodule : tb
